// file: common/eat_pkg.sv
// package: register map, reset values and state counts for area timing
// Functional notes
// RQ1: per-area bit selects two or three states
// RQ2: length bits all ones on reset, standby
// RQ3: on-chip accesses use fixed state count
// RQ4: single-chip modes ignore length bits
// RQ5: DRAM areas ignore the length bit
// RQ6: two-state areas get no waits
// RQ7: width bit and two-bit wait count
// RQ8: basic or DRAM, area 0 burst ROM
// RQ9: mode 1 updates address every cycle
// RQ10: mode 2 updates only external, refresh
// RQ11: control bit selects mode, resets mode 1
package eat_pkg;
    localparam logic [7:0] OFF_AREA_LEN = 8'h00;
    localparam logic [7:0] OFF_BUS_WIDTH = 8'h04;
    localparam logic [7:0] OFF_WAIT_CTRL = 8'h08;
    localparam logic [7:0] OFF_DRAM_CTRL = 8'h0C;
    localparam logic [7:0] OFF_ADDR_CTRL = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;

    localparam logic [7:0] RST_AREA_LEN = 8'hFF;
    localparam logic [7:0] RST_BUS_WIDTH = 8'hFF;
    localparam logic [15:0] RST_WAIT_CTRL = 16'hFFFF;
    localparam logic [3:0] RST_DRAM_CTRL = 4'h0;
    localparam logic RST_ADDR_CTRL = 1'b0;

    // dram_control_a and address control field layout
    localparam int DRAM_SEL_LSB = 0;
    localparam int BROM_EN_BIT = 3;
    localparam int ADDR_MODE_BIT = 0;

    // state counts
    localparam logic [2:0] ONCHIP_STATES = 3'h2;
    localparam logic [2:0] SHORT_STATES = 3'h2;
    localparam logic [2:0] LONG_STATES = 3'h3;
    localparam logic [2:0] DRAM_STATES = 3'h3;
    localparam logic [2:0] BROM_STATES = 3'h3;

    localparam logic [2:0] MODE_SINGLE_A = 3'h6;
    localparam logic [2:0] MODE_SINGLE_B = 3'h7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        IF_BASIC = 2'h0,
        IF_DRAM = 2'h1,
        IF_BROM = 2'h2,
        IF_ONCHIP = 2'h3
    } eat_iface_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } eat_state_t;
endpackage : eat_pkg

// file: core/eat_addr_hold.sv
// module: external address output latch
module eat_addr_hold #(
    parameter int WIDTH = 24
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic load,
    input wire logic [WIDTH-1:0] addrIn,
    output logic [WIDTH-1:0] addrOut
);
    if (WIDTH < 3) begin : g_width_chk
        $error("address width too small");
    end

    logic [WIDTH-1:0] addr_reg;

    // holding the old value is what gives the memory its address hold time
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            addr_reg <= '0;
        end else if (load) begin
            addr_reg <= addrIn;
        end
    end

    assign addrOut = addr_reg;
endmodule : eat_addr_hold

// file: core/eat_area_timing.sv
// module: per-area external access timing and address output control
module eat_area_timing #(
    parameter int AXI_AW = 8,
    parameter int ADDR_W = 24
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic hwStandbyPin,
    input wire logic [2:0] opModePin,
    input wire logic accReq,
    output logic accReady,
    input wire logic [ADDR_W-1:0] accAddr,
    input wire logic accOnChip,
    input wire logic accSelfRefresh,
    output logic accBusy,
    output logic accDone,
    output logic [2:0] accStates,
    output logic [1:0] accWaits,
    output logic accBus8,
    output logic accExternal,
    output logic [1:0] accIface,
    output logic [ADDR_W-1:0] extAddr
);
    if (AXI_AW < 5 || AXI_AW > 32 || ADDR_W < 3 || ADDR_W > 32) begin : g_param_chk
        $error("address width parameter out of range");
    end
    ////////////////
    // pin synchronisers
    logic hwStbyMeta_reg, hwStbySync_reg;
    logic [2:0] modeMeta_reg, modeSync_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hwStbyMeta_reg <= 1'b0;
            hwStbySync_reg <= 1'b0;
        end else begin
            hwStbyMeta_reg <= hwStandbyPin;
            hwStbySync_reg <= hwStbyMeta_reg;
        end
    end

    // mode straps are static; two stages are enough
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            modeMeta_reg <= 3'h0;
            modeSync_reg <= 3'h0;
        end else begin
            modeMeta_reg <= opModePin;
            modeSync_reg <= modeMeta_reg;
        end
    end

    logic singleChip;
    assign singleChip = (modeSync_reg == eat_pkg::MODE_SINGLE_A)
        || (modeSync_reg == eat_pkg::MODE_SINGLE_B);
    ////////////////
    // register bus
    logic wrEn, wrErr, rdErr;
    logic [AXI_AW-1:0] wrAddr, rdAddr;
    logic [31:0] wrData, rdData;
    logic [3:0] wrStrb;

    eat_axil_slave #(
        .AW(AXI_AW)
    ) u_slave (
        .clk_sys,
        .nrst,
        .s_axi_awaddr,
        .s_axi_awvalid,
        .s_axi_awready,
        .s_axi_wdata,
        .s_axi_wstrb,
        .s_axi_wvalid,
        .s_axi_wready,
        .s_axi_bresp,
        .s_axi_bvalid,
        .s_axi_bready,
        .s_axi_araddr,
        .s_axi_arvalid,
        .s_axi_arready,
        .s_axi_rdata,
        .s_axi_rresp,
        .s_axi_rvalid,
        .s_axi_rready,
        .wrEn,
        .wrAddr,
        .wrData,
        .wrStrb,
        .wrErr,
        .rdAddr,
        .rdData,
        .rdErr
    );

    logic [7:0] areaLen_reg, busWidth_reg;
    logic [15:0] waitCtrl_reg;
    logic [3:0] dramCtrl_reg;
    logic addrCtrl_reg;
    logic selLen, selWidth, selWait, selDram, selAddr;
    assign selLen = wrAddr == AXI_AW'(eat_pkg::OFF_AREA_LEN);
    assign selWidth = wrAddr == AXI_AW'(eat_pkg::OFF_BUS_WIDTH);
    assign selWait = wrAddr == AXI_AW'(eat_pkg::OFF_WAIT_CTRL);
    assign selDram = wrAddr == AXI_AW'(eat_pkg::OFF_DRAM_CTRL);
    assign selAddr = wrAddr == AXI_AW'(eat_pkg::OFF_ADDR_CTRL);
    // status is read-only, so a write to it is refused like a hole
    assign wrErr = !(selLen || selWidth || selWait || selDram || selAddr);

    // software standby is not an input: the bits simply keep their value
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            areaLen_reg <= eat_pkg::RST_AREA_LEN; // RQ2
        end else if (hwStbySync_reg) begin
            areaLen_reg <= eat_pkg::RST_AREA_LEN; // RQ2
        end else if (wrEn && selLen && wrStrb[0]) begin
            areaLen_reg <= wrData[7:0]; // RQ1
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busWidth_reg <= eat_pkg::RST_BUS_WIDTH;
        end else if (wrEn && selWidth && wrStrb[0]) begin
            busWidth_reg <= wrData[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            waitCtrl_reg <= eat_pkg::RST_WAIT_CTRL;
        end else if (wrEn && selWait) begin
            if (wrStrb[0]) begin
                waitCtrl_reg[7:0] <= wrData[7:0];
            end
            if (wrStrb[1]) begin
                waitCtrl_reg[15:8] <= wrData[15:8];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dramCtrl_reg <= eat_pkg::RST_DRAM_CTRL;
        end else if (wrEn && selDram && wrStrb[0]) begin
            dramCtrl_reg <= wrData[3:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            addrCtrl_reg <= eat_pkg::RST_ADDR_CTRL; // RQ11
        end else if (wrEn && selAddr && wrStrb[0]) begin
            addrCtrl_reg <= wrData[eat_pkg::ADDR_MODE_BIT]; // RQ11
        end
    end
    ////////////////
    // access planning
    eat_pkg::eat_state_t state_reg;
    logic [2:0] area_reg, remain_reg, reqArea, dramSel, planStates;
    logic areaIsDram, areaIsBrom, planExt, planBus8, take;
    logic [1:0] planWaits;
    eat_pkg::eat_iface_t planIface;

    assign reqArea = accAddr[ADDR_W-1 -: 3];
    assign dramSel = dramCtrl_reg[eat_pkg::DRAM_SEL_LSB +: 3];
    // codes 1..4 map areas 2..(code+1) to DRAM; other codes select none
    assign areaIsDram = (dramSel >= 3'h1) && (dramSel <= 3'h4)
        && (reqArea >= 3'h2) && (reqArea <= dramSel + 3'h1); // RQ8
    assign areaIsBrom = dramCtrl_reg[eat_pkg::BROM_EN_BIT]
        && (reqArea == 3'h0); // RQ8
    // no external space exists in single-chip modes
    assign planExt = !accOnChip && !singleChip; // RQ4

    always_comb begin
        planStates = eat_pkg::ONCHIP_STATES;
        planWaits = 2'h0;
        planBus8 = 1'b0;
        planIface = eat_pkg::IF_ONCHIP;
        if (!planExt) begin
            planStates = eat_pkg::ONCHIP_STATES; // RQ3
        end else if (areaIsDram) begin
            planStates = eat_pkg::DRAM_STATES; // RQ5
            planBus8 = busWidth_reg[reqArea];
            planIface = eat_pkg::IF_DRAM;
        end else if (areaIsBrom) begin
            planStates = eat_pkg::BROM_STATES;
            planBus8 = busWidth_reg[reqArea];
            planIface = eat_pkg::IF_BROM;
        end else begin
            planBus8 = busWidth_reg[reqArea]; // RQ7
            planIface = eat_pkg::IF_BASIC;
            if (areaLen_reg[reqArea]) begin
                planWaits = waitCtrl_reg[{reqArea, 1'b0} +: 2]; // RQ7
                planStates = eat_pkg::LONG_STATES + {1'b0, planWaits}; // RQ1
            end else begin
                planWaits = 2'h0; // RQ6
                planStates = eat_pkg::SHORT_STATES; // RQ1
            end
        end
    end
    ////////////////
    // access sequencer
    // one new access is taken only from idle
    assign accReady = state_reg == eat_pkg::ST_IDLE;
    assign take = accReady && accReq;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= eat_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                eat_pkg::ST_IDLE: begin
                    if (take) begin
                        state_reg <= eat_pkg::ST_RUN;
                    end
                end
                eat_pkg::ST_RUN: begin
                    if (remain_reg == 3'h1) begin
                        state_reg <= eat_pkg::ST_DONE;
                    end
                end
                eat_pkg::ST_DONE: begin
                    state_reg <= eat_pkg::ST_IDLE;
                end
                default: begin
                    state_reg <= eat_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // one clock per state; the done cycle closes the last state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            remain_reg <= 3'h0;
        end else if (take) begin
            remain_reg <= planStates - 3'h1;
        end else if (state_reg == eat_pkg::ST_RUN && remain_reg != 3'h0) begin
            remain_reg <= remain_reg - 3'h1;
        end
    end

    logic [2:0] states_reg;
    logic [1:0] waits_reg, iface_reg;
    logic bus8_reg, ext_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            area_reg <= 3'h0;
            states_reg <= 3'h0;
            waits_reg <= 2'h0;
            bus8_reg <= 1'b0;
            ext_reg <= 1'b0;
            iface_reg <= 2'h0;
        end else if (take) begin
            area_reg <= reqArea;
            states_reg <= planStates;
            waits_reg <= planWaits;
            bus8_reg <= planBus8;
            ext_reg <= planExt;
            iface_reg <= planIface;
        end
    end

    assign accBusy = state_reg != eat_pkg::ST_IDLE;
    assign accDone = state_reg == eat_pkg::ST_DONE;
    assign accStates = states_reg;
    assign accWaits = waits_reg;
    assign accBus8 = bus8_reg;
    assign accExternal = ext_reg;
    assign accIface = iface_reg;
    ////////////////
    // address output
    logic addrLoad;
    // mode 2 keeps the last external address across on-chip cycles unless accSelfRefresh is set
    assign addrLoad = take && (!addrCtrl_reg // RQ9
        || planExt || accSelfRefresh); // RQ10

    eat_addr_hold #(
        .WIDTH(ADDR_W)
    ) u_addr (
        .clk_sys,
        .nrst,
        .load(addrLoad),
        .addrIn(accAddr),
        .addrOut(extAddr)
    );
    ////////////////
    // register read
    always_comb begin
        rdData = 32'h0;
        rdErr = 1'b0;
        if (rdAddr == AXI_AW'(eat_pkg::OFF_AREA_LEN)) begin
            rdData = {24'h0, areaLen_reg};
        end else if (rdAddr == AXI_AW'(eat_pkg::OFF_BUS_WIDTH)) begin
            rdData = {24'h0, busWidth_reg};
        end else if (rdAddr == AXI_AW'(eat_pkg::OFF_WAIT_CTRL)) begin
            rdData = {16'h0, waitCtrl_reg};
        end else if (rdAddr == AXI_AW'(eat_pkg::OFF_DRAM_CTRL)) begin
            rdData = {28'h0, dramCtrl_reg};
        end else if (rdAddr == AXI_AW'(eat_pkg::OFF_ADDR_CTRL)) begin
            rdData = {31'h0, addrCtrl_reg};
        end else if (rdAddr == AXI_AW'(eat_pkg::OFF_STATUS)) begin
            rdData = {17'h0, modeSync_reg, singleChip, accBusy,
                area_reg, iface_reg, waits_reg, states_reg};
        end else begin
            rdErr = 1'b1;
        end
    end
endmodule : eat_area_timing

// file: core/eat_axil_slave.sv
// module: AXI4-Lite slave front end with register strobes
module eat_axil_slave #(
    parameter int AW = 8
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wrEn,
    output logic [AW-1:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrErr,
    output logic [AW-1:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdErr
);
    logic awHeld_reg, wHeld_reg, bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, wdata_reg;
    logic [AW-1:0] awaddr_reg;
    logic [3:0] wstrb_reg;

    assign s_axi_awready = !awHeld_reg && !bvalid_reg;
    assign s_axi_wready = !wHeld_reg && !bvalid_reg;
    assign wrEn = awHeld_reg && wHeld_reg && !bvalid_reg;
    assign wrAddr = awaddr_reg;
    assign wrData = wdata_reg;
    assign wrStrb = wstrb_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            awHeld_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (wrEn) begin
            awHeld_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wHeld_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wrEn) begin
            wHeld_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= eat_pkg::RESP_OKAY;
        end else if (wrEn) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wrErr ? eat_pkg::RESP_SLVERR : eat_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_reg;
    assign rdAddr = s_axi_araddr;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= eat_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rdData;
            rresp_reg <= rdErr ? eat_pkg::RESP_SLVERR : eat_pkg::RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule : eat_axil_slave

// file: verification/eat_area_timing_asserts.sv
// checker: timing, address and read relations of the top block
module eat_area_timing_chk #(
    parameter int AXI_AW = 8,
    parameter int ADDR_W = 24
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic accReq,
    input wire logic accReady,
    input wire logic accBusy,
    input wire logic accDone,
    input wire logic [2:0] accStates,
    input wire logic [1:0] accWaits,
    input wire logic [1:0] accIface,
    input wire logic [ADDR_W-1:0] extAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    wire take = accReq && accReady;
    ////////////////
    take_busy_a: assert property (take |=> accBusy [*2])
        else $error("busy not held after take");
    done_bound_a: assert property (take |-> ##[2:7] accDone)
        else $error("access did not end in time");
    done_pulse_a: assert property (accDone |=> !accDone)
        else $error("done longer than one cycle");
    busy_ready_a: assert property (accBusy |-> !accReady)
        else $error("ready while busy");
    basic_states_a: assert property (accDone && accIface == eat_pkg::IF_BASIC |->
        (accStates == 3'h2 && accWaits == 2'h0) || accStates == 3'h3 + {1'b0, accWaits})
        else $error("basic state count wrong");
    onchip_states_a: assert property (accDone && accIface == eat_pkg::IF_ONCHIP |->
        accStates == 3'h2)
        else $error("on-chip state count wrong");
    dram_states_a: assert property (accDone && accIface inside {2'h1, 2'h2} |->
        accStates == 3'h3)
        else $error("dram or burst state count wrong");
    // the address may only move at an accepted access, never between them
    addr_hold_a: assert property (!$stable(extAddr) |-> $past(take))
        else $error("address moved without access");
    rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 'h14
        |=> s_axi_rresp == eat_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule : eat_area_timing_chk

bind eat_area_timing eat_area_timing_chk #(.AXI_AW(AXI_AW), .ADDR_W(ADDR_W)) chk_inst (.*);

// file: verification/eat_ext_mem.sv
// model of the external memory side: keeps the address of each external access
module eat_ext_mem #(
    parameter int ADDR_W = 24
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic accDone,
    input wire logic accExternal,
    input wire logic [ADDR_W-1:0] extAddr,
    output logic [ADDR_W-1:0] lastAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    // sampled at the end of the cycle, where a real part latches the address
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lastAddr <= '0;
        end else if (accDone && accExternal) begin
            lastAddr <= extAddr;
        end
    end
endmodule : eat_ext_mem

// file: verification/tb.sv
// testbench for the area timing block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] len;
        logic [7:0] wid;
        logic [15:0] wt;
        logic [3:0] dr;
        logic [2:0] area;
        logic onc;
        logic [2:0] st;
        logic [1:0] wa;
        logic b8;
        logic [1:0] ifc;
    } eat_tb_row_t;
    // length, width, waits, dram, area, on-chip -> states, waits, 8-bit, interface
    eat_tb_row_t rows [10] = '{
        '{8'hFF, 8'h00, 16'h0000, 4'h0, 3'h0, 1'b0, 3'h3, 2'h0, 1'b0, 2'h0},
        '{8'hFF, 8'h00, 16'h0001, 4'h0, 3'h0, 1'b0, 3'h4, 2'h1, 1'b0, 2'h0},
        '{8'hFF, 8'h00, 16'h0002, 4'h0, 3'h0, 1'b0, 3'h5, 2'h2, 1'b0, 2'h0},
        '{8'hFF, 8'h01, 16'h0003, 4'h0, 3'h0, 1'b0, 3'h6, 2'h3, 1'b1, 2'h0},
        '{8'hFE, 8'h00, 16'h0003, 4'h0, 3'h0, 1'b0, 3'h2, 2'h0, 1'b0, 2'h0},
        '{8'h7F, 8'hFF, 16'hC000, 4'h0, 3'h7, 1'b0, 3'h2, 2'h0, 1'b1, 2'h0},
        '{8'hF7, 8'h00, 16'h0000, 4'h0, 3'h3, 1'b0, 3'h2, 2'h0, 1'b0, 2'h0},
        '{8'hFF, 8'h00, 16'h0003, 4'h0, 3'h0, 1'b1, 3'h2, 2'h0, 1'b0, 2'h3},
        '{8'h00, 8'h00, 16'h0000, 4'h1, 3'h2, 1'b0, 3'h3, 2'h0, 1'b0, 2'h1},
        '{8'hFF, 8'h00, 16'h0003, 4'h8, 3'h0, 1'b0, 3'h3, 2'h0, 1'b0, 2'h2}
    };
    logic [31:0] rstVal [5] = '{32'hFF, 32'hFF, 32'hFFFF, 32'h0, 32'h0};
    logic clk_sys, nrst, awValid, wValid, bReady, arValid, rReady, hwStandbyPin;
    logic accReq, accOnChip, accSelfRefresh, awReady, wReady, bValid, arReady, rValid;
    logic accReady, accBusy, accDone, accBus8, accExternal;
    logic [7:0] awAddr, arAddr;
    logic [31:0] wData, rData, rd;
    logic [2:0] opModePin, accStates;
    logic [23:0] accAddr, extAddr, memLast;
    logic [1:0] bResp, rResp, accWaits, accIface, rsp;
    int mismatches = 0;
    int numChecks = 0;
    int cycles = 0;

    eat_area_timing eat_area_timing_inst (
        .clk_sys, .nrst, .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .hwStandbyPin, .opModePin, .accReq, .accReady, .accAddr, .accOnChip,
        .accSelfRefresh, .accBusy, .accDone, .accStates, .accWaits, .accBus8,
        .accExternal, .accIface, .extAddr
    );
    eat_ext_mem eat_ext_mem_inst (
        .clk_sys, .nrst, .accDone, .accExternal, .extAddr, .lastAddr(memLast)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    ////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // ready is read mid-cycle, once settled after the edge
    task automatic axWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aP = 1'b1;
        logic wP = 1'b1;
        @(posedge clk_sys);
        {awAddr, wData} <= {a, d};
        {awValid, wValid, bReady} <= 3'h7;
        while (aP || wP) begin
            @(negedge clk_sys);
            aP = aP && !awReady;
            wP = wP && !wReady;
            @(posedge clk_sys);
            awValid <= aP;
            wValid <= wP;
        end
        do @(negedge clk_sys); while (!bValid);
        r = bResp;
        @(posedge clk_sys);
        bReady <= 1'b0;
    endtask : axWr

    // ready for the data comes a cycle late, so the slave must hold it
    task automatic axRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        arAddr <= a;
        arValid <= 1'b1;
        do @(negedge clk_sys); while (!arReady);
        @(posedge clk_sys);
        arValid <= 1'b0;
        do @(negedge clk_sys); while (!rValid);
        @(posedge clk_sys);
        rReady <= 1'b1;
        @(negedge clk_sys);
        d = rData;
        r = rResp;
        @(posedge clk_sys);
        rReady <= 1'b0;
    endtask : axRd

    task automatic acc(input logic [23:0] a, input logic onc, input logic sr);
        @(posedge clk_sys);
        {accReq, accAddr, accOnChip, accSelfRefresh} <= {1'b1, a, onc, sr};
        do @(negedge clk_sys); while (!accReady);
        @(posedge clk_sys);
        accReq <= 1'b0;
        do @(negedge clk_sys); while (!accDone);
    endtask : acc

    task automatic doReset();
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask : doReset

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    ////////////////
    initial begin
        nrst = 1'b0;
        {awValid, wValid, bReady, arValid, rReady, hwStandbyPin, accReq} = '0;
        {accOnChip, accSelfRefresh, awAddr, arAddr, wData, accAddr, opModePin} = '0;
        doReset();
        foreach (rows[i]) begin
            axWr(eat_pkg::OFF_AREA_LEN, 32'(rows[i].len), rsp);
            axWr(eat_pkg::OFF_BUS_WIDTH, 32'(rows[i].wid), rsp);
            axWr(eat_pkg::OFF_WAIT_CTRL, 32'(rows[i].wt), rsp);
            axWr(eat_pkg::OFF_DRAM_CTRL, 32'(rows[i].dr), rsp);
            acc({rows[i].area, 21'h000ABC}, rows[i].onc, 1'b0);
            chk(32'(accStates), 32'(rows[i].st));
            chk(32'(accIface), 32'(rows[i].ifc));
            chk(32'(accExternal), 32'(!rows[i].onc));
            if (rows[i].ifc == 2'h0) begin
                chk(32'(accWaits), 32'(rows[i].wa));
                chk(32'(accBus8), 32'(rows[i].b8));
            end
        end
        // mid-run reset: programmed values must not survive
        doReset();
        for (int i = 0; i < 5; i++) begin
            axRd(8'(4 * i), rd, rsp);
            chk(rd, rstVal[i]);
        end
        axRd(8'h18, rd, rsp);
        chk(32'(rsp), 32'(eat_pkg::RESP_SLVERR));
        chk(rd, 32'h0);
        axWr(eat_pkg::OFF_STATUS, 32'h0, rsp);
        chk(32'(rsp), 32'(eat_pkg::RESP_SLVERR));
        acc(24'h200100, 1'b0, 1'b0);
        chk(32'(extAddr), 32'h200100);
        acc(24'h000222, 1'b1, 1'b0);
        chk(32'(extAddr), 32'h000222);
        chk(32'(memLast), 32'h200100);
        axWr(eat_pkg::OFF_ADDR_CTRL, 32'h1, rsp);
        acc(24'h300333, 1'b0, 1'b0);
        chk(32'(extAddr), 32'h300333);
        acc(24'h000444, 1'b1, 1'b0);
        chk(32'(extAddr), 32'h300333);
        acc(24'h000555, 1'b1, 1'b1);
        chk(32'(extAddr), 32'h000555);
        axRd(eat_pkg::OFF_ADDR_CTRL, rd, rsp);
        chk(rd, 32'h1);
        axWr(eat_pkg::OFF_AREA_LEN, 32'h0, rsp);
        axWr(eat_pkg::OFF_BUS_WIDTH, 32'h12, rsp);
        hwStandbyPin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        axWr(eat_pkg::OFF_AREA_LEN, 32'h55, rsp);
        axRd(eat_pkg::OFF_AREA_LEN, rd, rsp);
        chk(rd, 32'hFF);
        hwStandbyPin <= 1'b0;
        axRd(eat_pkg::OFF_BUS_WIDTH, rd, rsp);
        chk(rd, 32'h12);
        for (int m = 6; m < 8; m++) begin
            @(posedge clk_sys);
            opModePin <= 3'(m);
            repeat (4) @(posedge clk_sys);
            acc(24'h400000, 1'b0, 1'b0);
            chk(32'(accStates), 32'(eat_pkg::ONCHIP_STATES));
        end
        test_done();
    end
endmodule : tb
